/* rtl/adcfg_bank.v */
/*
 Output and digital configuration bank of the converter, with the
 output coding, pattern, offset correction and power controls.
 Assumes ADC_CODE offset binary, one sample per SYS_CLK, and the
 serial port strobes synchronous to SYS_CLK.
*/
`timescale 1ns/1ps
`include "adcfg_defines.vh"
module adcfg_bank (
  input wire SYS_CLK,
  input wire RST,
  input wire CFG_SEL_N,
  input wire CFG_SHIFT,
  input wire CFG_SDI,
  input wire CFG_READ,
  output wire CFG_SDO,
  input wire [13:0] ADC_CODE,
  input wire FORMAT_SELECT_PIN,
  input wire INTERFACE_SELECT_PIN,
  input wire NARROW_VARIANT,
  input wire CUSTOM_PATTERN_ON,
  output reg [13:0] DOUT,
  output reg DOUT_OE,
  output reg LVDS_MODE,
  output reg [1:0] RISE_EDGE_POSITION,
  output reg RISE_ALIGNED,
  output reg [1:0] FALL_EDGE_POSITION,
  output reg CLOCK_BUFFER_DRIVE,
  output reg DATA_BUFFER_DRIVE,
  output reg [1:0] CMOS_CLOCK_DRIVE,
  output reg SWING_CTRL_ON,
  output reg HIGH_FREQ_TUNING,
  output reg CONV_POWER_ON,
  output reg REF_POWER_ON,
  output reg DIGITAL_FUNCTIONS_ON,
  output reg [13:0] OFFSET_ESTIMATE
);

  // Saturate a 17-bit signed sum to 14 bits
  function [13:0] adcfg_sat14;
    input [16:0] v;
    begin
      if (!v[16] && (v[15:13] != 3'b000))
        adcfg_sat14 = `ADCFG_SAT_POS;
      else if (v[16] && (v[15:13] != 3'b111))
        adcfg_sat14 = `ADCFG_SAT_NEG;
      else
        adcfg_sat14 = v[13:0];
    end
  endfunction

  // Place a word on 14 or 12 output bits
  function [13:0] adcfg_fit;
    input [13:0] w;
    input narrow;
    begin
      if (narrow)
        adcfg_fit = {2'b00, w[13:2]};
      else
        adcfg_fit = w;
    end
  endfunction

  // Pin-or-force decode of a two-bit select
  function adcfg_pick;
    input [1:0] code;
    input [1:0] force_on;
    input [1:0] force_off;
    input pin;
    begin
      if (code == force_on)
        adcfg_pick = 1'b1;
      else if (code == force_off)
        adcfg_pick = 1'b0;
      else
        adcfg_pick = pin;
    end
  endfunction

  reg [7:0] reg_drive;
  reg [7:0] reg_coding;
  reg [7:0] reg_pat_hi;
  reg [7:0] reg_pat_lo;
  reg [7:0] reg_iface;
  reg [7:0] reg_fall;
  reg [7:0] reg_power;
  reg [7:0] reg_perf;
  reg [7:0] reg_bias;
  reg [7:0] reg_loop;
  reg [7:0] rd_data;

  wire [7:0] port_addr;
  wire [7:0] port_data;
  wire port_wr;
  wire [13:0] est;

  adcfg_serial_port u_port (
    .clk(SYS_CLK),
    .rst(RST),
    .sel_n(CFG_SEL_N),
    .shift(CFG_SHIFT),
    .sdi(CFG_SDI),
    .read(CFG_READ),
    .rd_data(rd_data),
    .addr(port_addr),
    .wr_data(port_data),
    .wr_stb(port_wr),
    .sdo(CFG_SDO)
  );

  // Register writes, reserved bits dropped
  always @(posedge SYS_CLK)
  begin
    if (RST)
    begin
      reg_drive <= `ADCFG_RST_VAL;
      reg_coding <= `ADCFG_RST_VAL;
      reg_pat_hi <= `ADCFG_RST_VAL;
      reg_pat_lo <= `ADCFG_RST_VAL;
      reg_iface <= `ADCFG_RST_VAL;
      reg_fall <= `ADCFG_RST_VAL;
      reg_power <= `ADCFG_RST_VAL;
      reg_perf <= `ADCFG_RST_VAL;
      reg_bias <= `ADCFG_RST_VAL;
      reg_loop <= `ADCFG_RST_VAL;
    end
    else if (port_wr)
    begin
      case (port_addr)
        `ADCFG_OFS_DRIVE:
          reg_drive <= port_data & `ADCFG_MSK_DRIVE;
        `ADCFG_OFS_CODING:
          reg_coding <= port_data & `ADCFG_MSK_CODING;
        `ADCFG_OFS_PAT_HI:
          reg_pat_hi <= port_data & `ADCFG_MSK_PAT_HI;
        `ADCFG_OFS_PAT_LO:
          reg_pat_lo <= port_data & `ADCFG_MSK_PAT_LO;
        `ADCFG_OFS_IFACE:
          reg_iface <= port_data & `ADCFG_MSK_IFACE;
        `ADCFG_OFS_FALL:
          reg_fall <= port_data & `ADCFG_MSK_FALL;
        `ADCFG_OFS_POWER:
          reg_power <= port_data & `ADCFG_MSK_POWER;
        `ADCFG_OFS_PERF:
          reg_perf <= port_data & `ADCFG_MSK_PERF;
        `ADCFG_OFS_BIAS:
          reg_bias <= port_data & `ADCFG_MSK_BIAS;
        `ADCFG_OFS_LOOP:
          reg_loop <= port_data & `ADCFG_MSK_LOOP;
        default:
          reg_drive <= reg_drive;
      endcase
    end
  end

  // Readback, unmapped addresses read zero
  always @*
  begin
    case (port_addr)
      `ADCFG_OFS_DRIVE: rd_data = reg_drive;
      `ADCFG_OFS_CODING: rd_data = reg_coding;
      `ADCFG_OFS_PAT_HI: rd_data = reg_pat_hi;
      `ADCFG_OFS_PAT_LO: rd_data = reg_pat_lo;
      `ADCFG_OFS_IFACE: rd_data = reg_iface;
      `ADCFG_OFS_FALL: rd_data = reg_fall;
      `ADCFG_OFS_POWER: rd_data = reg_power;
      `ADCFG_OFS_PERF: rd_data = reg_perf;
      `ADCFG_OFS_BIAS: rd_data = reg_bias;
      `ADCFG_OFS_LOOP: rd_data = reg_loop;
      default: rd_data = `ADCFG_RST_VAL;
    endcase
  end

  // Field decode
  wire [1:0] fmt_code = reg_coding[`ADCFG_PAIR_HI:`ADCFG_PAIR_LO];
  wire [1:0] if_code = reg_iface[`ADCFG_PAIR_HI:`ADCFG_PAIR_LO];
  wire [1:0] rise_pos = reg_iface[`ADCFG_RISE_HI:`ADCFG_RISE_LO];
  wire [1:0] fall_pos = reg_fall[`ADCFG_PAIR_HI:`ADCFG_PAIR_LO];
  wire [1:0] swing_en = reg_power[`ADCFG_SWING_HI:`ADCFG_SWING_LO];
  wire [5:0] pedestal = reg_bias[`ADCFG_PED_HI:`ADCFG_PED_LO];
  wire [3:0] settle = reg_loop[`ADCFG_TC_HI:`ADCFG_TC_LO];
  wire [13:0] pattern = {reg_pat_hi, reg_pat_lo[`ADCFG_PED_HI:`ADCFG_PED_LO]};
  wire digital_on = reg_fall[`ADCFG_DIGITAL_BIT];
  wire sleep = reg_fall[`ADCFG_SLEEP_BIT];
  wire shutdown = reg_power[`ADCFG_SHUTDOWN_BIT];
  wire pins_off = reg_power[`ADCFG_OBUF_BIT];
  wire loop_run = digital_on & reg_coding[`ADCFG_OFSON_BIT];
  wire hold = reg_loop[`ADCFG_HOLD_BIT];

  // Converter and buffer power state
  wire conv_on = ~(sleep | shutdown);
  wire bufs_on = conv_on & ~pins_off;

  // Interface and coding choice
  wire lvds = adcfg_pick(if_code, `ADCFG_IF_LVDS, `ADCFG_IF_CMOS,
    INTERFACE_SELECT_PIN);
  wire twos = adcfg_pick(fmt_code, `ADCFG_FMT_TWOS, `ADCFG_FMT_OBIN,
    FORMAT_SELECT_PIN);

  // Sample about mid-code in twos complement
  wire [13:0] sample_s = ADC_CODE ^ `ADCFG_MID_FLIP;

  adcfg_offset_loop u_loop (
    .clk(SYS_CLK),
    .rst(RST),
    .run(loop_run),
    .hold(hold),
    .settle(settle),
    .sample(sample_s),
    .est(est)
  );

  // Corrected sample plus signed pedestal
  wire [16:0] corr_sum = {{3{sample_s[13]}}, sample_s}
    - {{3{est[13]}}, est}
    + {{11{pedestal[5]}}, pedestal};
  wire [13:0] twos_word = loop_run ? adcfg_sat14(corr_sum) : sample_s;
  wire [13:0] coded = twos ? twos_word
    : (twos_word ^ `ADCFG_MID_FLIP);
  wire [13:0] word = (digital_on & CUSTOM_PATTERN_ON) ? pattern
    : coded;
  wire [13:0] next_dout = bufs_on ? adcfg_fit(word, NARROW_VARIANT)
    : 14'h0;

  // Output edge placement
  wire [1:0] next_rise = reg_iface[`ADCFG_RISE_EN_BIT] ? rise_pos
    : `ADCFG_EDGE_DEFAULT;
  wire [1:0] next_fall = reg_iface[`ADCFG_FALL_EN_BIT] ? fall_pos
    : `ADCFG_EDGE_DEFAULT;

  // Registered outputs, one clock after a write
  always @(posedge SYS_CLK)
  begin
    if (RST)
    begin
      DOUT <= 14'h0;
      DOUT_OE <= 1'b0;
      LVDS_MODE <= 1'b0;
      RISE_EDGE_POSITION <= `ADCFG_EDGE_DEFAULT;
      RISE_ALIGNED <= 1'b0;
      FALL_EDGE_POSITION <= `ADCFG_EDGE_DEFAULT;
      CLOCK_BUFFER_DRIVE <= 1'b0;
      DATA_BUFFER_DRIVE <= 1'b0;
      CMOS_CLOCK_DRIVE <= 2'b00;
      SWING_CTRL_ON <= 1'b0;
      HIGH_FREQ_TUNING <= 1'b0;
      CONV_POWER_ON <= 1'b0;
      REF_POWER_ON <= 1'b0;
      DIGITAL_FUNCTIONS_ON <= 1'b0;
      OFFSET_ESTIMATE <= 14'h0;
    end
    else
    begin
      DOUT <= next_dout;
      DOUT_OE <= bufs_on;
      LVDS_MODE <= lvds;
      RISE_EDGE_POSITION <= next_rise;
      RISE_ALIGNED <= lvds & (next_rise == `ADCFG_RISE_ALIGN);
      FALL_EDGE_POSITION <= next_fall;
      CLOCK_BUFFER_DRIVE <= reg_drive[`ADCFG_CLK_DRV_BIT];
      DATA_BUFFER_DRIVE <= reg_drive[`ADCFG_DATA_DRV_BIT];
      CMOS_CLOCK_DRIVE <= reg_iface[`ADCFG_CMOS_HI:`ADCFG_CMOS_LO];
      SWING_CTRL_ON <= (swing_en == `ADCFG_SWING_ON);
      HIGH_FREQ_TUNING <= reg_perf[`ADCFG_TUNING_BIT];
      CONV_POWER_ON <= conv_on;
      REF_POWER_ON <= ~shutdown;
      DIGITAL_FUNCTIONS_ON <= digital_on;
      OFFSET_ESTIMATE <= est;
    end
  end
endmodule // adcfg_bank

/* rtl/adcfg_defines.vh */
/*
 Constants of the ADC output and digital configuration bank.
 Assumes inclusion by bare name from the design files.
*/
`ifndef ADCFG_DEFINES_VH
`define ADCFG_DEFINES_VH
// Register offsets
`define ADCFG_OFS_DRIVE 8'h26
`define ADCFG_OFS_CODING 8'h3d
`define ADCFG_OFS_PAT_HI 8'h3f
`define ADCFG_OFS_PAT_LO 8'h40
`define ADCFG_OFS_IFACE 8'h41
`define ADCFG_OFS_FALL 8'h42
`define ADCFG_OFS_POWER 8'h43
`define ADCFG_OFS_PERF 8'h4a
`define ADCFG_OFS_BIAS 8'hbf
`define ADCFG_OFS_LOOP 8'hcf
// Implemented bits
`define ADCFG_MSK_DRIVE 8'h03
`define ADCFG_MSK_CODING 8'he0
`define ADCFG_MSK_PAT_HI 8'hff
`define ADCFG_MSK_PAT_LO 8'hfc
`define ADCFG_MSK_IFACE 8'hff
`define ADCFG_MSK_FALL 8'hcc
`define ADCFG_MSK_POWER 8'h53
`define ADCFG_MSK_PERF 8'h01
`define ADCFG_MSK_BIAS 8'hfc
`define ADCFG_MSK_LOOP 8'hbc
`define ADCFG_RST_VAL 8'h00
// Field positions
`define ADCFG_CLK_DRV_BIT 1
`define ADCFG_DATA_DRV_BIT 0
`define ADCFG_PAIR_HI 7
`define ADCFG_PAIR_LO 6
`define ADCFG_OFSON_BIT 5
`define ADCFG_CMOS_HI 5
`define ADCFG_CMOS_LO 4
`define ADCFG_RISE_EN_BIT 3
`define ADCFG_RISE_HI 2
`define ADCFG_RISE_LO 1
`define ADCFG_FALL_EN_BIT 0
`define ADCFG_DIGITAL_BIT 3
`define ADCFG_SLEEP_BIT 2
`define ADCFG_SHUTDOWN_BIT 6
`define ADCFG_OBUF_BIT 4
`define ADCFG_SWING_HI 1
`define ADCFG_SWING_LO 0
`define ADCFG_TUNING_BIT 0
`define ADCFG_PED_HI 7
`define ADCFG_PED_LO 2
`define ADCFG_HOLD_BIT 7
`define ADCFG_TC_HI 5
`define ADCFG_TC_LO 2
// Codes
`define ADCFG_FMT_TWOS 2'b10
`define ADCFG_FMT_OBIN 2'b11
`define ADCFG_IF_LVDS 2'b01
`define ADCFG_IF_CMOS 2'b11
`define ADCFG_SWING_ON 2'b11
`define ADCFG_EDGE_DEFAULT 2'b00
`define ADCFG_RISE_ALIGN 2'b10
`define ADCFG_MID_FLIP 14'h2000
`define ADCFG_SAT_POS 14'h1fff
`define ADCFG_SAT_NEG 14'h2000
`define ADCFG_TC_BASE 6'd20
`define ADCFG_TC_MAX 4'hb
`define ADCFG_LAST_BIT 3'd7
`endif

/* rtl/adcfg_offset_loop.v */
/*
 Offset estimator: leaky integrator with 2^(20+code) time constant.
 Assumes twos-complement samples about mid-code, one per clock.
*/
`timescale 1ns/1ps
`include "adcfg_defines.vh"
module adcfg_offset_loop (
  input wire clk,
  input wire rst,
  input wire run,
  input wire hold,
  input wire [3:0] settle,
  input wire [13:0] sample,
  output reg [13:0] est
);
  reg signed [47:0] acc;
  wire [3:0] code = (settle > `ADCFG_TC_MAX) ? `ADCFG_TC_MAX : settle;
  wire [5:0] shift = `ADCFG_TC_BASE + {2'b00, code};
  wire signed [47:0] diff = $signed({{34{sample[13]}}, sample})
    - $signed({{34{est[13]}}, est});
  wire signed [47:0] next_acc = acc + diff;
  wire signed [47:0] scaled = next_acc >>> shift;
  always @(posedge clk)
  begin
    if (rst | ~run)
    begin
      acc <= 48'h0;
      est <= 14'h0;
    end
    else if (!hold)
    begin
      acc <= next_acc;
      est <= scaled[13:0];
    end
  end
endmodule // adcfg_offset_loop

/* rtl/adcfg_serial_port.v */
/*
 Serial configuration port: address byte then data byte, MSB first.
 Assumes CFG strobes synchronous to the system clock.
*/
`timescale 1ns/1ps
`include "adcfg_defines.vh"
module adcfg_serial_port (
  input wire clk,
  input wire rst,
  input wire sel_n,
  input wire shift,
  input wire sdi,
  input wire read,
  input wire [7:0] rd_data,
  output reg [7:0] addr,
  output reg [7:0] wr_data,
  output reg wr_stb,
  output reg sdo
);
  localparam ST_ADDR = 3'b001;
  localparam ST_DATA = 3'b010;
  localparam ST_DONE = 3'b100;
  reg [2:0] state;
  reg [2:0] cnt;
  reg [7:0] shreg;
  wire [7:0] next_shreg = {shreg[6:0], sdi};
  always @(posedge clk)
  begin
    wr_stb <= 1'b0;
    if (rst)
    begin
      state <= ST_ADDR;
      cnt <= 3'd0;
      shreg <= `ADCFG_RST_VAL;
      addr <= `ADCFG_RST_VAL;
      wr_data <= `ADCFG_RST_VAL;
      sdo <= 1'b0;
    end
    else if (sel_n)
    begin
      state <= ST_ADDR;
      cnt <= 3'd0;
      sdo <= 1'b0;
    end
    else
    begin
      // Readback bit for the next shift
      sdo <= (state == ST_DATA) & read & rd_data[`ADCFG_LAST_BIT - cnt];
      if (shift)
      begin
        case (state)
          ST_ADDR:
          begin
            shreg <= next_shreg;
            cnt <= cnt + 3'd1;
            if (cnt == `ADCFG_LAST_BIT)
            begin
              addr <= next_shreg;
              state <= ST_DATA;
            end
          end
          ST_DATA:
          begin
            shreg <= next_shreg;
            cnt <= cnt + 3'd1;
            if (cnt == `ADCFG_LAST_BIT)
            begin
              wr_data <= next_shreg;
              wr_stb <= ~read;
              state <= ST_DONE;
            end
          end
          ST_DONE:
            state <= ST_DONE;
          default:
            state <= ST_ADDR;
        endcase
      end
    end
  end
endmodule // adcfg_serial_port

/* testbench/adcfg_bank_chk.sv */
/*
 Port checker of the configuration bank.
 Assumes binding to adcfg_bank from the testbench top.
*/
`timescale 1ns/1ps
module adcfg_bank_chk (
  input wire SYS_CLK,
  input wire RST,
  input wire CFG_SEL_N,
  input wire CFG_SHIFT,
  input wire [13:0] ADC_CODE,
  input wire NARROW_VARIANT,
  input wire [13:0] DOUT,
  input wire DOUT_OE,
  input wire LVDS_MODE,
  input wire [1:0] RISE_EDGE_POSITION,
  input wire RISE_ALIGNED,
  input wire CLOCK_BUFFER_DRIVE,
  input wire SWING_CTRL_ON,
  input wire HIGH_FREQ_TUNING,
  input wire CONV_POWER_ON,
  input wire REF_POWER_ON,
  input wire DIGITAL_FUNCTIONS_ON,
  input wire [13:0] OFFSET_ESTIMATE
);
  reg [3:0] since_shift;
  wire [2:0] cfg = {CLOCK_BUFFER_DRIVE, SWING_CTRL_ON, HIGH_FREQ_TUNING};
  // Cycles since last serial bit
  always @(posedge SYS_CLK)
  begin
    if (RST)
      since_shift <= 4'hf;
    else if (CFG_SHIFT && !CFG_SEL_N)
      since_shift <= 4'h0;
    else if (since_shift != 4'hf)
      since_shift <= since_shift + 4'h1;
  end
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RST);
  a_reset_clears: assert property (disable iff (1'b0)
    RST |=> DOUT == 14'h0 && !DOUT_OE && !CONV_POWER_ON && !REF_POWER_ON
    && OFFSET_ESTIMATE == 14'h0) else $error("outputs not cleared");
  a_shutdown_all: assert property (!REF_POWER_ON |-> !CONV_POWER_ON)
    else $error("converter on without reference");
  a_sleep_obuf: assert property (!CONV_POWER_ON |-> !DOUT_OE)
    else $error("buffers on while converter off");
  a_hiz_quiet: assert property (!DOUT_OE |-> DOUT == 14'h0)
    else $error("data moves while buffers off");
  a_rise_align: assert property (RISE_ALIGNED |-> LVDS_MODE
    && RISE_EDGE_POSITION == 2'b10) else $error("bad align flag");
  a_write_timing: assert property ($changed(cfg) |->
    since_shift inside {[1:6]}) else $error("config moved off a write");
  a_data_coding: assert property (DOUT_OE && $past(DOUT_OE)
    && !DIGITAL_FUNCTIONS_ON && !$past(DIGITAL_FUNCTIONS_ON)
    && !$past(NARROW_VARIANT) |-> (DOUT ^ $past(ADC_CODE))
    inside {14'h0000, 14'h2000}) else $error("bad bypass coding");
  a_narrow_top: assert property ($past(NARROW_VARIANT) |->
    DOUT[13:12] == 2'b00) else $error("narrow top bits set");
  c_aligned: cover property (RISE_ALIGNED);
  c_shutdown: cover property (!REF_POWER_ON);
  c_narrow: cover property (NARROW_VARIANT && DIGITAL_FUNCTIONS_ON);
endmodule // adcfg_bank_chk

/* testbench/adcfg_bank_tb.sv */
/*
 Self-checking bench of the configuration bank.
 Assumes the host model and checker files compiled first.
*/
`timescale 1ns/1ps
`define CHK(a, b) begin checks = checks + 1; if ((a) !== (b)) begin \
  miscompares = miscompares + 1; \
  $display("unexpected at %0t: got %h want %h", $time, a, b); end end
module adcfg_bank_tb;
  typedef struct packed {
    logic [7:0] a;
    logic [7:0] d;
    logic [7:0] q;
    logic [15:0] o;
  } adcfg_row_t;
  reg SYS_CLK = 1'b0;
  reg RST = 1'b1;
  reg [13:0] ADC_CODE = 14'h0123;
  reg FORMAT_SELECT_PIN = 1'b0;
  reg INTERFACE_SELECT_PIN = 1'b0;
  reg NARROW_VARIANT = 1'b0;
  reg CUSTOM_PATTERN_ON = 1'b0;
  wire CFG_SEL_N, CFG_SHIFT, CFG_SDI, CFG_READ, CFG_SDO, LVDS_MODE;
  wire DOUT_OE, RISE_ALIGNED, CLOCK_BUFFER_DRIVE, DATA_BUFFER_DRIVE;
  wire SWING_CTRL_ON, HIGH_FREQ_TUNING, CONV_POWER_ON, REF_POWER_ON;
  wire DIGITAL_FUNCTIONS_ON;
  wire [1:0] RISE_EDGE_POSITION, FALL_EDGE_POSITION, CMOS_CLOCK_DRIVE;
  wire [13:0] DOUT, OFFSET_ESTIMATE;
  wire [15:0] outs = {LVDS_MODE, RISE_EDGE_POSITION, RISE_ALIGNED,
    FALL_EDGE_POSITION, CLOCK_BUFFER_DRIVE, DATA_BUFFER_DRIVE,
    CMOS_CLOCK_DRIVE, SWING_CTRL_ON, HIGH_FREQ_TUNING, CONV_POWER_ON,
    REF_POWER_ON, DIGITAL_FUNCTIONS_ON, DOUT_OE};
  localparam [31:0] FMTS = {8'hc0, 8'h80, 8'h00, 8'h00};
  localparam [3:0] PINS = 4'b1010;
  localparam [3:0] FLIPS = 4'b0110;
  integer miscompares = 0;
  integer checks = 0;
  integer i;
  reg [7:0] q;
  adcfg_row_t rows [0:18];
  adcfg_bank dut (.SYS_CLK(SYS_CLK), .RST(RST), .CFG_SEL_N(CFG_SEL_N),
    .CFG_SHIFT(CFG_SHIFT), .CFG_SDI(CFG_SDI), .CFG_READ(CFG_READ),
    .CFG_SDO(CFG_SDO), .ADC_CODE(ADC_CODE),
    .FORMAT_SELECT_PIN(FORMAT_SELECT_PIN),
    .INTERFACE_SELECT_PIN(INTERFACE_SELECT_PIN),
    .NARROW_VARIANT(NARROW_VARIANT), .CUSTOM_PATTERN_ON(CUSTOM_PATTERN_ON),
    .DOUT(DOUT), .DOUT_OE(DOUT_OE), .LVDS_MODE(LVDS_MODE),
    .RISE_EDGE_POSITION(RISE_EDGE_POSITION), .RISE_ALIGNED(RISE_ALIGNED),
    .FALL_EDGE_POSITION(FALL_EDGE_POSITION),
    .CLOCK_BUFFER_DRIVE(CLOCK_BUFFER_DRIVE),
    .DATA_BUFFER_DRIVE(DATA_BUFFER_DRIVE),
    .CMOS_CLOCK_DRIVE(CMOS_CLOCK_DRIVE), .SWING_CTRL_ON(SWING_CTRL_ON),
    .HIGH_FREQ_TUNING(HIGH_FREQ_TUNING), .CONV_POWER_ON(CONV_POWER_ON),
    .REF_POWER_ON(REF_POWER_ON),
    .DIGITAL_FUNCTIONS_ON(DIGITAL_FUNCTIONS_ON),
    .OFFSET_ESTIMATE(OFFSET_ESTIMATE));
  adcfg_host host (.clk(SYS_CLK), .sdo(CFG_SDO), .sel_n(CFG_SEL_N),
    .shift(CFG_SHIFT), .sdi(CFG_SDI), .read(CFG_READ));
  always #2 SYS_CLK = ~SYS_CLK;
  task stop_test;
    begin
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    begin
      host.xfer(a, d, 1'b0, q);
    end
  endtask
  initial
  begin
    repeat (20000) @(posedge SYS_CLK);
    miscompares = miscompares + 1;
    stop_test;
  end
  initial
  begin
    rows[0] = '{8'h26, 8'h03, 8'h03, 16'b0_00_0_00_1_1_00_0_0_1_1_0_1};
    rows[1] = '{8'h4a, 8'hff, 8'h01, 16'b0_00_0_00_1_1_00_0_1_1_1_0_1};
    rows[2] = '{8'h43, 8'h03, 8'h03, 16'b0_00_0_00_1_1_00_1_1_1_1_0_1};
    rows[3] = '{8'h41, 8'h7c, 8'h7c, 16'b1_10_1_00_1_1_11_1_1_1_1_0_1};
    rows[4] = '{8'h42, 8'hc1, 8'hc0, 16'b1_10_1_00_1_1_11_1_1_1_1_0_1};
    rows[5] = '{8'h41, 8'hfd, 8'hfd, 16'b0_10_0_11_1_1_11_1_1_1_1_0_1};
    rows[6] = '{8'h41, 8'h34, 8'h34, 16'b0_00_0_00_1_1_11_1_1_1_1_0_1};
    rows[7] = '{8'h42, 8'hc8, 8'hc8, 16'b0_00_0_00_1_1_11_1_1_1_1_1_1};
    rows[8] = '{8'h42, 8'h04, 8'h04, 16'b0_00_0_00_1_1_11_1_1_0_1_0_0};
    rows[9] = '{8'h43, 8'h53, 8'h53, 16'b0_00_0_00_1_1_11_1_1_0_0_0_0};
    rows[10] = '{8'h42, 8'h00, 8'h00, 16'b0_00_0_00_1_1_11_1_1_0_0_0_0};
    rows[11] = '{8'h43, 8'h13, 8'h13, 16'b0_00_0_00_1_1_11_1_1_1_1_0_0};
    rows[12] = '{8'h43, 8'h03, 8'h03, 16'b0_00_0_00_1_1_11_1_1_1_1_0_1};
    rows[13] = '{8'h3d, 8'he1, 8'he0, 16'b0_00_0_00_1_1_11_1_1_1_1_0_1};
    rows[14] = '{8'h3f, 8'ha5, 8'ha5, 16'b0_00_0_00_1_1_11_1_1_1_1_0_1};
    rows[15] = '{8'h40, 8'hff, 8'hfc, 16'b0_00_0_00_1_1_11_1_1_1_1_0_1};
    rows[16] = '{8'hbf, 8'hff, 8'hfc, 16'b0_00_0_00_1_1_11_1_1_1_1_0_1};
    rows[17] = '{8'hcf, 8'hff, 8'hbc, 16'b0_00_0_00_1_1_11_1_1_1_1_0_1};
    rows[18] = '{8'h10, 8'hff, 8'h00, 16'b0_00_0_00_1_1_11_1_1_1_1_0_1};
    repeat (19) @(posedge SYS_CLK);
    #1;
    `CHK({outs, DOUT, OFFSET_ESTIMATE, CFG_SDO}, 45'h0)
    @(posedge SYS_CLK);
    RST <= 1'b0;
    repeat (3) @(posedge SYS_CLK);
    #1;
    `CHK(outs, 16'b0_00_0_00_0_0_00_0_0_1_1_0_1)
    for (i = 0; i < 19; i = i + 1)
    begin
      wr(rows[i].a, rows[i].d);
      #1;
      `CHK(outs, rows[i].o)
      host.xfer(rows[i].a, 8'h00, 1'b1, q);
      `CHK(q, rows[i].q)
    end
    for (i = 0; i < 4; i = i + 1)
    begin
      wr(8'h3d, FMTS[8 * i +: 8]);
      FORMAT_SELECT_PIN <= PINS[i];
      repeat (3) @(posedge SYS_CLK);
      #1;
      `CHK(DOUT, FLIPS[i] ? 14'h2123 : 14'h0123)
    end
    wr(8'h42, 8'h08);
    CUSTOM_PATTERN_ON <= 1'b1;
    repeat (3) @(posedge SYS_CLK);
    #1;
    `CHK(DOUT, 14'h297f)
    `CHK(OFFSET_ESTIMATE, 14'h0000)
    NARROW_VARIANT <= 1'b1;
    repeat (3) @(posedge SYS_CLK);
    #1;
    `CHK(DOUT, 14'h0a5f)
    wr(8'h42, 8'h00);
    #1;
    `CHK(DOUT, 14'h0048)
    @(posedge SYS_CLK);
    RST <= 1'b1;
    repeat (2) @(posedge SYS_CLK);
    RST <= 1'b0;
    for (i = 0; i < 19; i = i + 1)
    begin
      host.xfer(rows[i].a, 8'h00, 1'b1, q);
      `CHK(q, 8'h00)
    end
    stop_test;
  end
endmodule // adcfg_bank_tb
bind adcfg_bank adcfg_bank_chk chk (.SYS_CLK, .RST, .CFG_SEL_N,
  .CFG_SHIFT, .ADC_CODE, .NARROW_VARIANT, .DOUT, .DOUT_OE, .LVDS_MODE,
  .RISE_EDGE_POSITION, .RISE_ALIGNED, .CLOCK_BUFFER_DRIVE, .SWING_CTRL_ON,
  .HIGH_FREQ_TUNING, .CONV_POWER_ON, .REF_POWER_ON, .DIGITAL_FUNCTIONS_ON,
  .OFFSET_ESTIMATE);

/* testbench/adcfg_host.sv */
/*
 Host model of the serial configuration port.
 Assumes the bank samples strobes on the rising clock edge.
*/
`timescale 1ns/1ps
module adcfg_host (
  input wire clk,
  input wire sdo,
  output reg sel_n,
  output reg shift,
  output reg sdi,
  output reg read
);
  initial
  begin
    sel_n = 1'b1;
    shift = 1'b0;
    sdi = 1'b0;
    read = 1'b0;
  end
  // One frame; rd turns it into a readback
  task xfer(input [7:0] a, input [7:0] d, input rd, output [7:0] q);
    integer i;
    begin
      q = 8'h00;
      @(posedge clk);
      sel_n <= 1'b0;
      read <= rd;
      for (i = 0; i < 16; i = i + 1)
      begin
        @(posedge clk);
        shift <= 1'b1;
        sdi <= (i < 8) ? a[7 - i] : d[15 - i];
        @(posedge clk);
        shift <= 1'b0;
        @(posedge clk);
        #1;
        if (rd && i >= 7 && i < 15)
          q[14 - i] = sdo;
      end
      @(posedge clk);
      sel_n <= 1'b1;
      read <= 1'b0;
      repeat (2) @(posedge clk);
    end
  endtask
endmodule // adcfg_host
